//--- design/grx_ctrl.sv
/*
 * Serial control port, configuration words, sample clock selection and
 * sample pin formatting for a GPS receiver.
 * Assumes serial pins already synchronous to core_clk; the analog path
 * provides raw sign and magnitude bits and lock flags.
 */
`timescale 1ns/1ps
`include "grx_defs.svh"
`default_nettype none
module grx_ctrl #(
  parameter int LO_DIV = `GRX_LO_DIV,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe_n,
  input wire logic ref_clk_tick,
  input wire logic adc_sign,
  input wire logic [1:0] adc_mag,
  input wire logic lock_hi,
  input wire logic lock_lo,
  input wire logic [3:0] lpf_autotune,
  input wire logic lpf_cal_end,
  input wire logic parity_in,
  input wire logic sample_ready,
  output logic sample_valid,
  output logic sample_clock_out,
  output logic sample_bit_hi,
  output logic sample_bit_mid,
  output logic sample_bit_lo,
  output logic [7:0] ref_div,
  output logic [13:0] rf_lo_ratio,
  output logic [7:0] if_lo_ratio,
  output logic vco_x2,
  output logic [3:0] lpf_step,
  output logic lpf_autotune_go,
  output logic standby,
  output logic [3:0] adc_offset,
  output logic cp_double,
  output logic [2:0] vco_coarse,
  output logic [4:0] vga_gain,
  output logic [15:0] config_word_a,
  output logic [15:0] adc_pll_config_word,
  output logic [15:0] config_word_c
);
  // ****************************************
  // Serial port
  // ****************************************
  logic sclk_d_r;
  logic [4:0] bitcnt_r;
  logic [19:0] shift_r;
  logic [15:0] rd_r;
  grx_pkg::grx_ser_e st_r;
  logic sclk_rise;
  logic sclk_fall;
  logic [15:0] status_w;

  assign sclk_rise = ser_clk && !sclk_d_r;
  assign sclk_fall = !ser_clk && sclk_d_r;
  assign status_w = {6'h00, lock_hi, lock_lo, config_word_a[`GRX_SYN_CLKSEL], parity_in, 1'b0,
                     lpf_cal_end, lpf_autotune};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= ser_clk;
    end
  end

  // Chip-select high ends the word in progress; it commits only if exactly 20 bits came in
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= grx_pkg::GRX_IDLE;
      bitcnt_r <= 5'h00;
      shift_r <= 20'h0_0000;
    end else begin
      case (st_r)
        grx_pkg::GRX_IDLE: begin
          bitcnt_r <= 5'h00;
          if (!ser_cs_n) begin
            st_r <= grx_pkg::GRX_SHIFT;
          end
        end
        grx_pkg::GRX_SHIFT: begin
          if (ser_cs_n) begin
            st_r <= grx_pkg::GRX_DONE;
          end else if (sclk_rise) begin
            shift_r <= {shift_r[18:0], ser_din};
            if (bitcnt_r != 5'(`GRX_WORD_BITS + 1)) begin
              bitcnt_r <= bitcnt_r + 5'h01;
            end
          end
        end
        grx_pkg::GRX_DONE: begin
          st_r <= grx_pkg::GRX_IDLE;
        end
        default: begin
          st_r <= grx_pkg::GRX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Configuration words
  // ****************************************
  // Excess bits beyond twenty count as a short word too, keeping the frame honest
  logic commit;
  logic [3:0] waddr;
  assign commit = (st_r == grx_pkg::GRX_DONE) && (bitcnt_r == 5'(`GRX_WORD_BITS));
  assign waddr = shift_r[3:0];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      config_word_a <= `GRX_CONFIG_WORD_A_RST;
      adc_pll_config_word <= `GRX_CFG1_RST;
      config_word_c <= `GRX_CFG2_RST;
    end else if (commit) begin
      case (waddr)
        `GRX_ADDR_CONFIG_WORD_A: config_word_a <= shift_r[19:4];
        `GRX_ADDR_CFG1: adc_pll_config_word <= shift_r[19:4];
        `GRX_ADDR_CFG2: config_word_c <= shift_r[19:4];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  // Read word latched on the 4th bit, when address is known
  logic sdo_en;
  assign sdo_en = (adc_pll_config_word[`GRX_CF1_TBUS_HI:`GRX_CF1_TBUS_LO] == `GRX_TBUS_SDO_EN);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 16'h0000;
      ser_dout <= 1'b0;
      ser_dout_oe_n <= 1'b1;
    end else begin
      ser_dout_oe_n <= !(sdo_en && !ser_cs_n);
      if (st_r == grx_pkg::GRX_SHIFT && sclk_rise && bitcnt_r == 5'h03) begin
        if ({shift_r[2:0], ser_din} == `GRX_ADDR_STAT) begin
          rd_r <= status_w;
        end else begin
          rd_r <= 16'h0000;
        end
      end else if (st_r == grx_pkg::GRX_SHIFT && sclk_fall && bitcnt_r > 5'h04) begin
        ser_dout <= rd_r[15];
        rd_r <= {rd_r[14:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  assign ref_div = config_word_a[7:0];
  assign rf_lo_ratio = 14'(`GRX_RF_RATIO);
  assign if_lo_ratio = 8'(`GRX_IF_RATIO);
  assign lpf_step = config_word_a[`GRX_SYN_LPF_HI:`GRX_SYN_LPF_LO];
  assign lpf_autotune_go = config_word_a[`GRX_SYN_AUTOTUNE];
  assign standby = config_word_a[`GRX_SYN_STBY] && config_word_a[`GRX_SYN_CLKSEL];
  assign adc_offset = adc_pll_config_word[`GRX_CF1_OFS_HI:`GRX_CF1_OFS_LO];
  assign cp_double = adc_pll_config_word[`GRX_CF1_CP2X];
  assign vco_coarse = adc_pll_config_word[`GRX_CF1_VCO_HI:`GRX_CF1_VCO_LO];
  assign vga_gain = adc_pll_config_word[`GRX_CF1_GAIN_HI:`GRX_CF1_GAIN_LO];

  // ****************************************
  // Sample clock
  // ****************************************
  logic vco_tick;
  logic lo_q_r;
  logic lo_tick_r;
  logic lo96_tick;
  logic sclk_sel_tick;
  logic sclk_out_r;

  // Oscillator model tick stands for the twice-LO rate
  assign vco_tick = 1'b1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lo_q_r <= 1'b0;
      lo_tick_r <= 1'b0;
    end else begin
      lo_q_r <= vco_tick ? !lo_q_r : lo_q_r;
      lo_tick_r <= vco_tick && lo_q_r;
    end
  end
  assign vco_x2 = lo_q_r;

  grx_div #(.N(LO_DIV)) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .tick(lo96_tick)
  );

  // Divider runs on the core clock, so the 96 count is in twice-LO oscillator-model ticks
  assign sclk_sel_tick = config_word_a[`GRX_SYN_CLKSEL] ? ref_clk_tick : lo96_tick;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_out_r <= 1'b0;
    end else if (sclk_sel_tick) begin
      sclk_out_r <= !sclk_out_r;
    end
  end
  assign sample_clock_out = sclk_out_r;

  // ****************************************
  // Sample path
  // ****************************************
  logic [2:0] fmt_w;
  logic [2:0] q_data;
  logic f_ready;
  logic samp_stb;
  logic [2:0] pins_r;

  // Mode 1 is 2-bit, bottom pin don't care driven low
  assign fmt_w = adc_pll_config_word[`GRX_CF1_MODE] ? {adc_sign, adc_mag[0], 1'b0} :
                 {adc_mag[1], adc_mag[0], adc_sign};
  assign samp_stb = sclk_sel_tick && !sclk_out_r;

  grx_fifo #(.W(3), .D(FIFO_DEPTH), .AW(4)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(samp_stb),
    .in_ready(f_ready),
    .in_data(fmt_w),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(q_data)
  );

  // Serial reads never touch this path; only writes of the format bit and clock select reach it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pins_r <= 3'h0;
    end else if (sample_valid && sample_ready) begin
      pins_r <= q_data;
    end
  end
  assign sample_bit_hi = pins_r[2];
  assign sample_bit_mid = pins_r[1];
  assign sample_bit_lo = pins_r[0];
endmodule
`default_nettype wire

//--- design/grx_defs.svh
/*
 * Constants for the GPS receiver serial control block: word layout,
 * addresses, field positions, reset values and clock ratios.
 * Assumes inclusion by bare name from design files.
 */
// Operation
// - Samples are 2-bit or 3-bit by format bit
// - Sample clock is reference, or LO divided 96
// - Selected sample clock driven on output pin
// - Three sample pins, meaning set by format
// - LO ratios fixed at 8064 and 168
// - Oscillator at twice LO, halved in quadrature
// - Filter cutoff in 16 programmed steps
// - Four-bit offset trim at converter input
// - Gain set by controller over serial port
// - Status reports out-of-lock high and low
// - Bits accepted only while select held low
// - Serial output works only with test select 01
// - Reads never disturb sample output
// - Sixteen data bits then four address bits
// - Pin mapping per format mode
`ifndef GRX_DEFS_SVH
`define GRX_DEFS_SVH

// ****************************************
// Word layout and addresses
// ****************************************
`define GRX_WORD_BITS 20
`define GRX_DATA_BITS 16
`define GRX_ADDR_CONFIG_WORD_A 4'h4
`define GRX_ADDR_CFG1 4'h5
`define GRX_ADDR_CFG2 4'h6
`define GRX_ADDR_STAT 4'h7

// ****************************************
// Field positions
// ****************************************
`define GRX_SYN_CLKSEL 9
`define GRX_SYN_STBY 8
`define GRX_SYN_LPF_HI 13
`define GRX_SYN_LPF_LO 10
`define GRX_SYN_AUTOTUNE 14
`define GRX_CF1_MODE 15
`define GRX_CF1_OFS_HI 14
`define GRX_CF1_OFS_LO 11
`define GRX_CF1_CP2X 10
`define GRX_CF1_TBUS_HI 9
`define GRX_CF1_TBUS_LO 8
`define GRX_CF1_VCO_HI 7
`define GRX_CF1_VCO_LO 5
`define GRX_CF1_GAIN_HI 4
`define GRX_CF1_GAIN_LO 0
`define GRX_TBUS_SDO_EN 2'h1

// ****************************************
// Reset values
// ****************************************
`define GRX_CONFIG_WORD_A_RST 16'hd260
`define GRX_CFG1_RST 16'h8020
`define GRX_CFG2_RST 16'h0000

// ****************************************
// Clock ratios
// ****************************************
`define GRX_LO_DIV 96
`define GRX_RF_RATIO 8064
`define GRX_IF_RATIO 168

`endif

//--- design/grx_pkg.sv
/*
 * Types for the GPS receiver serial control block.
 * Assumes grx_defs.svh is available to design files.
 */
package grx_pkg;
  typedef enum logic [2:0] {
    GRX_IDLE = 3'b001,
    GRX_SHIFT = 3'b010,
    GRX_DONE = 3'b100
  } grx_ser_e;
  typedef logic [15:0] grx_word_t;
endpackage

//--- design/grx_div.sv
/*
 * Divide-by-N pulse generator, one tick every N clocks.
 * Assumes a free-running clock.
 */
`timescale 1ns/1ps
`default_nettype none
module grx_div #(
  parameter int N = 96
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic tick
);
  logic [15:0] cnt_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == 16'(N - 1)) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- design/grx_fifo.sv
/*
 * Synchronous FIFO for sample words, valid and ready on both sides.
 * Assumes one clock; read data is taken combinationally from the storage array at the read pointer.
 */
`timescale 1ns/1ps
`default_nettype none
module grx_fifo #(
  parameter int W = 3,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + AW'(1);
      end
      if (do_rd) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

//--- sim/grx_ctrl_checker.sv
/* Port checker for grx_ctrl.
   Assumes it is bound to grx_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module grx_ctrl_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_dout,
  input wire logic ser_dout_oe_n,
  input wire logic ref_clk_tick,
  input wire logic sample_clock_out,
  input wire logic [7:0] ref_div,
  input wire logic [13:0] rf_lo_ratio,
  input wire logic [7:0] if_lo_ratio,
  input wire logic [3:0] lpf_step,
  input wire logic [4:0] vga_gain,
  input wire logic [15:0] config_word_a,
  input wire logic [15:0] adc_pll_config_word,
  input wire logic [15:0] config_word_c
);
  // ********
  // Properties
  // ********
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_RF_RATIO: assert property (rf_lo_ratio == 14'h1f80) else $error("rf ratio wrong");
  AST_IF_RATIO: assert property (if_lo_ratio == 8'ha8) else $error("if ratio wrong");
  AST_CLK_REF: assert property (config_word_a[9] && $past(config_word_a[9]) |->
    $changed(sample_clock_out) == $past(ref_clk_tick)) else $error("sample clock not from ref");
  AST_SDO_EN: assert property (!ser_dout_oe_n |->
    $past(adc_pll_config_word[9:8]) == 2'h1 && !$past(ser_cs_n)) else $error("sdo driven");
  AST_COMMIT: assert property ($changed({config_word_a, adc_pll_config_word, config_word_c}) |->
    ser_cs_n && $past(ser_cs_n)) else $error("word changed in frame");
  AST_DOUT: assert property ($changed(ser_dout) && !ser_dout_oe_n |-> !$past(ser_clk))
    else $error("dout moved off fall");
  // Decodes checked only once the word has settled
  AST_REF_DIV: assert property ($stable(config_word_a) |-> ref_div == config_word_a[7:0])
    else $error("ref div decode");
  AST_LPF: assert property ($stable(config_word_a) |-> lpf_step == config_word_a[13:10])
    else $error("lpf decode");
  AST_GAIN: assert property ($stable(adc_pll_config_word) |-> vga_gain == adc_pll_config_word[4:0])
    else $error("gain decode");
endmodule
`default_nettype wire

//--- sim/grx_host.sv
/* Serial controller model driving the control port.
   Assumes core_clk is the bench clock; sclk idles low outside frames. */
`timescale 1ns/1ps
`default_nettype none
module grx_host (
  input wire logic core_clk,
  input wire logic ser_dout,
  input wire logic ser_dout_oe_n,
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_din
);
  logic oe_seen;
  initial begin
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_din = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge core_clk) begin
    if (!ser_dout_oe_n) begin
      oe_seen <= 1'b1;
    end
  end
  // ********
  // Frame
  // ********
  // Slow phases of four cycles keep well inside the two-cycle minimum
  task automatic xfer(input logic [19:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge core_clk);
    oe_seen = 1'b0;
    ser_cs_n = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      ser_din = w[19-i];
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b0;
      repeat (4) @(negedge core_clk);
      rd = {rd[14:0], ser_dout};
    end
    ser_cs_n = 1'b1;
    ser_din = ~ser_din;
    repeat (6) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
/* Self-checking bench for grx_ctrl.
   Assumes grx_host as serial controller and the checker bound below. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic core_clk = 1'b0, nrst = 1'b0, ref_clk_tick = 1'b0, adc_sign = 1'b1, lock_hi = 1'b1, lock_lo = 1'b0;
  logic lpf_cal_end = 1'b1, parity_in = 1'b1, sample_ready = 1'b1;
  logic [1:0] adc_mag = 2'h3;
  logic [3:0] lpf_autotune = 4'ha;
  logic ser_clk, ser_cs_n, ser_din, ser_dout, oe_n, sample_valid, sclk_out, hi, mid, lo, cp_double;
  logic [2:0] vco_coarse;
  logic [15:0] word_a, word_b, word_c, rd;
  int n_fail = 0, checked = 0, cyc = 0, k;
  always #2.5 core_clk = ~core_clk;
  grx_host host (.core_clk(core_clk), .ser_dout(ser_dout), .ser_dout_oe_n(oe_n), .ser_clk(ser_clk),
    .ser_cs_n(ser_cs_n), .ser_din(ser_din));
  grx_ctrl #(.LO_DIV(6)) uut (.core_clk(core_clk), .nrst(nrst), .ser_clk(ser_clk), .ser_cs_n(ser_cs_n),
    .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe_n(oe_n), .ref_clk_tick(ref_clk_tick),
    .adc_sign(adc_sign), .adc_mag(adc_mag), .lock_hi(lock_hi), .lock_lo(lock_lo), .lpf_autotune(lpf_autotune),
    .lpf_cal_end(lpf_cal_end), .parity_in(parity_in), .sample_ready(sample_ready), .sample_valid(sample_valid),
    .sample_clock_out(sclk_out), .sample_bit_hi(hi), .sample_bit_mid(mid), .sample_bit_lo(lo), .ref_div(),
    .rf_lo_ratio(), .if_lo_ratio(), .vco_x2(), .lpf_step(), .lpf_autotune_go(), .standby(), .adc_offset(),
    .cp_double(cp_double), .vco_coarse(vco_coarse), .vga_gain(), .config_word_a(word_a),
    .adc_pll_config_word(word_b), .config_word_c(word_c));
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    `CHK("word a", 16'hd260, word_a)
    `CHK("word b", 16'h8020, word_b)
    `CHK("word c", 16'h0000, word_c)
    host.xfer({4'h7, 16'h0000}, 20, rd);
    `CHK("sdo off", 1'b0, host.oe_seen)
    host.xfer({16'h85d3, 4'h5}, 20, rd);
    `CHK("word b", 16'h85d3, word_b)
    `CHK("cp double", 1'b1, cp_double)
    `CHK("coarse", 3'h6, vco_coarse)
    host.xfer({16'h0000, 4'h5}, 19, rd);
    `CHK("short", 16'h85d3, word_b)
    host.xfer({16'hffff, 4'h3}, 20, rd);
    `CHK("bad addr", {16'hd260, 16'h85d3, 16'h0000}, {word_a, word_b, word_c})
    host.xfer({16'h1234, 4'h6}, 20, rd);
    `CHK("word c", 16'h1234, word_c)
  endtask
  task automatic t_read;
    ref_clk_tick = 1'b1;
    host.xfer({4'h7, 16'h0000}, 20, rd);
    `CHK("status", 16'h02da, rd)
    lock_hi = 1'b0;
    lock_lo = 1'b1;
    parity_in = 1'b0;
    lpf_cal_end = 1'b0;
    lpf_autotune = 4'h5;
    host.xfer({4'h7, 16'h0000}, 20, rd);
    `CHK("status", 16'h0185, rd)
    ref_clk_tick = 1'b0;
  endtask
  task automatic t_lo;
    logic prev;
    host.xfer({16'hd030, 4'h4}, 20, rd);
    // First pass aligns to a toggle, second measures one half period
    for (int j = 0; j < 2; j++) begin
      k = 0;
      prev = sclk_out;
      while (sclk_out === prev && k < 60) begin
        @(negedge core_clk);
        k++;
      end
    end
    `CHK("lo div", 6, k)
    host.xfer({16'hd260, 4'h4}, 20, rd);
  endtask
  task automatic t_pins;
    ref_clk_tick = 1'b1;
    repeat (60) @(negedge core_clk);
    `CHK("2 bit pins", 3'b110, {hi, mid, lo})
    adc_mag = 2'h2;
    host.xfer({16'h05d3, 4'h5}, 20, rd);
    repeat (60) @(negedge core_clk);
    `CHK("3 bit pins", 3'b101, {hi, mid, lo})
  endtask
  task automatic t_fifo;
    sample_ready = 1'b0;
    repeat (100) @(negedge core_clk);
    ref_clk_tick = 1'b0;
    repeat (4) @(negedge core_clk);
    sample_ready = 1'b1;
    k = 0;
    while (sample_valid === 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    `CHK("fifo depth", 16, k)
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    t_regs();
    t_read();
    t_lo();
    t_pins();
    t_fifo();
    end_of_test();
  end
endmodule
bind grx_ctrl grx_ctrl_checker chk (.*);
`default_nettype wire
